// *** core/almcr_defines.svh ***
// Register offsets, field positions, reset values and timing figures of the alarm mask and control bank.
`ifndef ALMCR_DEFINES_SVH
`define ALMCR_DEFINES_SVH

`define ALMCR_ADDR_FAULT_FLAGS 8'h11
`define ALMCR_ADDR_INPUT_FLAGS 8'h12
`define ALMCR_ADDR_PLL_FLAGS 8'h13
`define ALMCR_ADDR_CALIB_FLAGS 8'h14
`define ALMCR_ADDR_FAULT_MASK 8'h17
`define ALMCR_ADDR_INPUT_MASK 8'h18
`define ALMCR_ADDR_LOCK_MASK 8'h19
`define ALMCR_ADDR_CALIB_MASK 8'h1a
`define ALMCR_ADDR_SOFT_RESET 8'h1c
`define ALMCR_ADDR_FREQ_STEP 8'h1d
`define ALMCR_ADDR_POWER_SYNC 8'h1e
`define ALMCR_ADDR_STEP_SELECT 8'h20
`define ALMCR_ADDR_SERIAL_MODE 8'h2b
`define ALMCR_ADDR_LOSS_ENABLE 8'h2c
`define ALMCR_ADDR_REQUAL_TIME 8'h2d
`define ALMCR_ADDR_TRIGGER0 8'h2e
`define ALMCR_ADDR_TRIGGER1 8'h30
`define ALMCR_ADDR_TRIGGER2 8'h32

`define ALMCR_RST_FAULT_MASK 8'h35
`define ALMCR_FAULT_USED 8'hef
`define ALMCR_BIT_CRYSTAL_LOSS 1
`define ALMCR_BIT_SOFT_ALL 0
`define ALMCR_BIT_STEP_UP 0
`define ALMCR_BIT_STEP_DOWN 1
`define ALMCR_BIT_LOW_POWER 0
`define ALMCR_BIT_HARD_RESET 1
`define ALMCR_BIT_DIV_SYNC 2
`define ALMCR_BIT_SINGLE_STEP 0
`define ALMCR_BIT_STEP_SOURCE 1
`define ALMCR_BIT_THREE_WIRE 3
`define ALMCR_BIT_CRYSTAL_DIS 4
`define ALMCR_STEP_CODE_RSVD 2'h1

`define ALMCR_CLK_PERIOD_PS 8000
`define ALMCR_TICK_TIME_PS 1000000000
`define ALMCR_REQUAL_T0_MS 10'h002
`define ALMCR_REQUAL_T1_MS 10'h064
`define ALMCR_REQUAL_T2_MS 10'h0c8
`define ALMCR_REQUAL_T3_MS 10'h3e8

`endif

// *** core/almcr_pkg.sv ***
// Types shared by the alarm mask and control bank.
package almcr_pkg;

    // One register access from the serial port decoder.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } almcr_reg_req_t;

    // Live alarm conditions from the detectors and PLLs.
    typedef struct packed {
        logic [7:0] fault;
        logic [3:0] missing;
        logic [3:0] offfreq;
        logic [3:0] unlocked;
        logic [3:0] holdover;
        logic [3:0] calib;
    } almcr_alarm_in_t;

    // Per-PLL step and reset pulses, plus whole-device soft reset and divider sync.
    typedef struct packed {
        logic soft_all;
        logic [3:0] pll_soft;
        logic [3:0] step_up;
        logic [3:0] step_down;
        logic div_sync;
    } almcr_pulse_t;

endpackage : almcr_pkg

// *** core/almcr_regs.sv ***
// Alarm mask, sticky flag, soft reset, frequency step and signal loss control registers.
//
// Overview of operation
// - Fault mask bits 1, 2, 5 block crystal loss, reference loss, bus timeout interrupts.
// - Input mask: bits 3:0 block signal loss, bits 7:4 off-frequency, per input.
// - Lock mask: bits 3:0 block unlock, bits 7:4 holdover, PLL A to D.
// - Calibration mask bits 7:4 block each PLL's calibration busy flag.
// - Writing one to soft reset bit 0 restarts and recalibrates the whole device.
// - Soft reset bits 1 to 4 restart only PLL A to D.
// - Soft resets, step strobes and divider sync clear themselves after acting.
// - Rising edge of step bit 0 steps up, bit 1 steps down.
// - Power bit 0 requests low power, bit 1 requests hard reset with reload.
// - Writing one to sync bit 2 aligns all output dividers.
// - Single step enable zero ignores select pins and select field.
// - Step source bit picks pins at zero, register field at one.
// - Select field 3:2 chooses PLL: 0 A, 2 C, 3 D, 1 reserved.
// - Output enable bit is active high, gated by the all-outputs control.
// - Serial mode bit 3 selects four-wire at zero, three-wire at one.
// - Signal loss detection for input n runs only while enable bit n is one.
// - Enable register bit 4 set disables crystal loss detection; default zero.
// - Returned clock must stay valid 2, 100, 200 or 1000 ms before alarm clears.
// - Three 16-bit loss trigger thresholds, each held in two byte registers.
// - Alarm flags are sticky and cleared by writing zero to the bit.
`timescale 1ns/10ps
`default_nettype none
`include "almcr_defines.svh"

module almcr_regs #(
    parameter int TICK_CYCLES = `ALMCR_TICK_TIME_PS / `ALMCR_CLK_PERIOD_PS
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire almcr_pkg::almcr_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire almcr_pkg::almcr_alarm_in_t alarm_in,
    input wire logic [1:0] pll_select_pins,
    input wire logic output_enable_zero,
    input wire logic all_outputs_gate,
    output logic irq,
    output almcr_pkg::almcr_pulse_t pulses,
    output logic low_power_request,
    output logic hard_reset_request,
    output logic three_wire_select,
    output logic outputs_driven,
    output logic [3:0] input_loss_alarm,
    output logic [3:0] input_loss_detect_enable,
    output logic crystal_loss_detect_disable,
    output logic [47:0] loss_trigger_threshold
);

    // Parameter check at elaboration.
    if (TICK_CYCLES < 1 || TICK_CYCLES > 16777215) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    // One-hot target for a two-bit PLL code.
    function automatic logic [3:0] pll_onehot(input logic [1:0] code);
        logic [3:0] hot;
        hot = 4'h0;
        hot[code] = 1'b1;
        return hot;
    endfunction : pll_onehot

    // Write strobe for one address.
    function automatic logic wr_hit(input almcr_pkg::almcr_reg_req_t req, input logic [7:0] addr);
        return req.wr && (req.addr == addr);
    endfunction : wr_hit

    logic [7:0] fault_flags, next_fault_flags;
    logic [7:0] input_flags, next_input_flags;
    logic [7:0] pll_flags, next_pll_flags;
    logic [3:0] calib_flags, next_calib_flags;
    logic [7:0] fault_interrupt_mask, next_fault_interrupt_mask;
    logic [7:0] input_alarm_mask, next_input_alarm_mask;
    logic [7:0] lock_holdover_mask, next_lock_holdover_mask;
    logic [3:0] calib_busy_irq_mask, next_calib_busy_irq_mask;
    logic [1:0] power_bits, next_power_bits;
    logic [3:0] step_target_select, next_step_target_select;
    logic three_wire, next_three_wire;
    logic [4:0] signal_loss_enable, next_signal_loss_enable;
    logic [7:0] signal_loss_requal_time, next_signal_loss_requal_time;
    logic [47:0] trigger, next_trigger;
    logic [7:0] rdata, next_rdata;
    logic irq_q, next_irq;
    logic outputs_q, next_outputs;
    almcr_pkg::almcr_pulse_t pulse_q, next_pulse;
    logic [23:0] tick_cnt, next_tick_cnt;
    logic tick, next_tick;
    logic [3:0] alarm_q, next_alarm;
    logic [39:0] requal_cnt, next_requal_cnt;
    logic [3:0] step_target;
    logic step_allowed;
    logic [7:0] fault_cond;
    logic pending_any;

    // Steering of frequency steps to one PLL or to all of them.
    always_comb begin
        step_target = 4'hf;
        step_allowed = 1'b1;
        if (step_target_select[`ALMCR_BIT_SINGLE_STEP]) begin
            if (step_target_select[`ALMCR_BIT_STEP_SOURCE]) begin
                step_target = pll_onehot(step_target_select[3:2]);
                step_allowed = step_target_select[3:2] != `ALMCR_STEP_CODE_RSVD;
            end else begin
                step_target = pll_onehot(pll_select_pins);
            end
        end
    end

    // Conditions that set the fault flags; crystal loss obeys its disable.
    always_comb begin
        fault_cond = alarm_in.fault & `ALMCR_FAULT_USED;
        if (signal_loss_enable[`ALMCR_BIT_CRYSTAL_DIS]) begin
            fault_cond[`ALMCR_BIT_CRYSTAL_LOSS] = 1'b0;
        end
    end

    // Register writes, sticky flags, self-clearing pulses and read data.
    always_comb begin
        next_fault_interrupt_mask = fault_interrupt_mask;
        next_input_alarm_mask = input_alarm_mask;
        next_lock_holdover_mask = lock_holdover_mask;
        next_calib_busy_irq_mask = calib_busy_irq_mask;
        next_power_bits = power_bits;
        next_step_target_select = step_target_select;
        next_three_wire = three_wire;
        next_signal_loss_enable = signal_loss_enable;
        next_signal_loss_requal_time = signal_loss_requal_time;
        next_trigger = trigger;
        next_pulse = '0;
        // A flag set in the same cycle as its clear write stays set.
        next_fault_flags = fault_cond | (fault_flags &
            ~({8{wr_hit(reg_req, `ALMCR_ADDR_FAULT_FLAGS)}} & ~reg_req.wdata));
        next_input_flags = {alarm_in.offfreq, alarm_q} | (input_flags &
            ~({8{wr_hit(reg_req, `ALMCR_ADDR_INPUT_FLAGS)}} & ~reg_req.wdata));
        next_pll_flags = {alarm_in.holdover, alarm_in.unlocked} | (pll_flags &
            ~({8{wr_hit(reg_req, `ALMCR_ADDR_PLL_FLAGS)}} & ~reg_req.wdata));
        next_calib_flags = alarm_in.calib | (calib_flags &
            ~({4{wr_hit(reg_req, `ALMCR_ADDR_CALIB_FLAGS)}} & ~reg_req.wdata[7:4]));
        if (reg_req.wr) begin
            case (reg_req.addr)
                `ALMCR_ADDR_FAULT_MASK: next_fault_interrupt_mask = reg_req.wdata;
                `ALMCR_ADDR_INPUT_MASK: next_input_alarm_mask = reg_req.wdata;
                `ALMCR_ADDR_LOCK_MASK: next_lock_holdover_mask = reg_req.wdata;
                `ALMCR_ADDR_CALIB_MASK: next_calib_busy_irq_mask = reg_req.wdata[7:4];
                `ALMCR_ADDR_SOFT_RESET: begin
                    next_pulse.soft_all = reg_req.wdata[`ALMCR_BIT_SOFT_ALL];
                    next_pulse.pll_soft = reg_req.wdata[4:1];
                end
                `ALMCR_ADDR_FREQ_STEP: begin
                    // Each written one is a rising edge, since the bit reads back as zero.
                    next_pulse.step_up = step_target & {4{step_allowed && reg_req.wdata[`ALMCR_BIT_STEP_UP]}};
                    next_pulse.step_down = step_target & {4{step_allowed && reg_req.wdata[`ALMCR_BIT_STEP_DOWN]}};
                end
                `ALMCR_ADDR_POWER_SYNC: begin
                    next_power_bits = reg_req.wdata[1:0];
                    next_pulse.div_sync = reg_req.wdata[`ALMCR_BIT_DIV_SYNC];
                end
                `ALMCR_ADDR_STEP_SELECT: next_step_target_select = reg_req.wdata[3:0];
                `ALMCR_ADDR_SERIAL_MODE: next_three_wire = reg_req.wdata[`ALMCR_BIT_THREE_WIRE];
                `ALMCR_ADDR_LOSS_ENABLE: next_signal_loss_enable = reg_req.wdata[4:0];
                `ALMCR_ADDR_REQUAL_TIME: next_signal_loss_requal_time = reg_req.wdata;
                default: begin
                    // Trigger thresholds: low byte first, high byte at the next address.
                    for (int i = 0; i < 6; i++) begin
                        if (reg_req.addr == `ALMCR_ADDR_TRIGGER0 + 8'(i)) begin
                            next_trigger[i*8 +: 8] = reg_req.wdata;
                        end
                    end
                end
            endcase
        end
        next_rdata = 8'h00;
        if (reg_req.rd) begin
            case (reg_req.addr)
                `ALMCR_ADDR_FAULT_FLAGS: next_rdata = fault_flags;
                `ALMCR_ADDR_INPUT_FLAGS: next_rdata = input_flags;
                `ALMCR_ADDR_PLL_FLAGS: next_rdata = pll_flags;
                `ALMCR_ADDR_CALIB_FLAGS: next_rdata = {calib_flags, 4'h0};
                `ALMCR_ADDR_FAULT_MASK: next_rdata = fault_interrupt_mask;
                `ALMCR_ADDR_INPUT_MASK: next_rdata = input_alarm_mask;
                `ALMCR_ADDR_LOCK_MASK: next_rdata = lock_holdover_mask;
                `ALMCR_ADDR_CALIB_MASK: next_rdata = {calib_busy_irq_mask, 4'h0};
                `ALMCR_ADDR_POWER_SYNC: next_rdata = {6'h00, power_bits};
                `ALMCR_ADDR_STEP_SELECT: next_rdata = {4'h0, step_target_select};
                `ALMCR_ADDR_SERIAL_MODE: next_rdata = {4'h0, three_wire, 3'h0};
                `ALMCR_ADDR_LOSS_ENABLE: next_rdata = {3'h0, signal_loss_enable};
                `ALMCR_ADDR_REQUAL_TIME: next_rdata = signal_loss_requal_time;
                default: begin
                    for (int i = 0; i < 6; i++) begin
                        if (reg_req.addr == `ALMCR_ADDR_TRIGGER0 + 8'(i)) begin
                            next_rdata = trigger[i*8 +: 8];
                        end
                    end
                end
            endcase
        end
    end

    // Interrupt from any unmasked sticky flag, and the gated output enable.
    always_comb begin
        pending_any = |(fault_flags & ~fault_interrupt_mask)
            | |(input_flags & ~input_alarm_mask)
            | |(pll_flags & ~lock_holdover_mask)
            | |(calib_flags & ~calib_busy_irq_mask);
        next_irq = pending_any;
        next_outputs = all_outputs_gate && output_enable_zero;
    end

    // Millisecond tick divider for the requalification timers.
    always_comb begin
        next_tick = 1'b0;
        next_tick_cnt = tick_cnt + 24'h000001;
        if (tick_cnt == 24'(TICK_CYCLES - 1)) begin
            next_tick_cnt = 24'h000000;
            next_tick = 1'b1;
        end
    end

    // Per-input loss alarm with requalification before it clears.
    for (genvar n = 0; n < 4; n++) begin : g_requal
        logic [9:0] limit;
        always_comb begin
            case (signal_loss_requal_time[2*n +: 2])
                2'h0: limit = `ALMCR_REQUAL_T0_MS;
                2'h1: limit = `ALMCR_REQUAL_T1_MS;
                2'h2: limit = `ALMCR_REQUAL_T2_MS;
                default: limit = `ALMCR_REQUAL_T3_MS;
            endcase
            next_alarm[n] = alarm_q[n];
            next_requal_cnt[n*10 +: 10] = requal_cnt[n*10 +: 10];
            if (!signal_loss_enable[n]) begin
                next_alarm[n] = 1'b0;
                next_requal_cnt[n*10 +: 10] = 10'h000;
            end else if (alarm_in.missing[n]) begin
                next_alarm[n] = 1'b1;
                next_requal_cnt[n*10 +: 10] = 10'h000;
            end else if (alarm_q[n] && tick) begin
                // The count starts over whenever the clock goes missing again.
                if (requal_cnt[n*10 +: 10] + 10'h001 >= limit) begin
                    next_alarm[n] = 1'b0;
                    next_requal_cnt[n*10 +: 10] = 10'h000;
                end else begin
                    next_requal_cnt[n*10 +: 10] = requal_cnt[n*10 +: 10] + 10'h001;
                end
            end
        end
    end

    // State registers.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fault_flags <= 8'h00;
            input_flags <= 8'h00;
            pll_flags <= 8'h00;
            calib_flags <= 4'h0;
            fault_interrupt_mask <= `ALMCR_RST_FAULT_MASK;
            input_alarm_mask <= 8'h00;
            lock_holdover_mask <= 8'h00;
            calib_busy_irq_mask <= 4'h0;
            power_bits <= 2'h0;
            step_target_select <= 4'h0;
            three_wire <= 1'b0;
            signal_loss_enable <= 5'h00;
            signal_loss_requal_time <= 8'h00;
            trigger <= 48'h000000000000;
            rdata <= 8'h00;
            reg_rvalid <= 1'b0;
            irq_q <= 1'b0;
            outputs_q <= 1'b0;
            pulse_q <= '0;
            tick_cnt <= 24'h000000;
            tick <= 1'b0;
            alarm_q <= 4'h0;
            requal_cnt <= 40'h0000000000;
        end else begin
            fault_flags <= next_fault_flags;
            input_flags <= next_input_flags;
            pll_flags <= next_pll_flags;
            calib_flags <= next_calib_flags;
            fault_interrupt_mask <= next_fault_interrupt_mask;
            input_alarm_mask <= next_input_alarm_mask;
            lock_holdover_mask <= next_lock_holdover_mask;
            calib_busy_irq_mask <= next_calib_busy_irq_mask;
            power_bits <= next_power_bits;
            step_target_select <= next_step_target_select;
            three_wire <= next_three_wire;
            signal_loss_enable <= next_signal_loss_enable;
            signal_loss_requal_time <= next_signal_loss_requal_time;
            trigger <= next_trigger;
            rdata <= next_rdata;
            reg_rvalid <= reg_req.rd;
            irq_q <= next_irq;
            outputs_q <= next_outputs;
            pulse_q <= next_pulse;
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
            alarm_q <= next_alarm;
            requal_cnt <= next_requal_cnt;
        end
    end

    // Outputs, each taken straight from a flip-flop.
    assign reg_rdata = rdata;
    assign irq = irq_q;
    assign pulses = pulse_q;
    assign low_power_request = power_bits[`ALMCR_BIT_LOW_POWER];
    assign hard_reset_request = power_bits[`ALMCR_BIT_HARD_RESET];
    assign three_wire_select = three_wire;
    assign outputs_driven = outputs_q;
    assign input_loss_alarm = alarm_q;
    assign input_loss_detect_enable = signal_loss_enable[3:0];
    assign crystal_loss_detect_disable = signal_loss_enable[`ALMCR_BIT_CRYSTAL_DIS];
    assign loss_trigger_threshold = trigger;

    // Checks on the register behaviour.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    a_irq_has_cause: assert property (irq |-> $past(pending_any))
        else $error("interrupt without an unmasked flag");
    a_fault_mask_blocks: assert property ((fault_flags[5] && fault_interrupt_mask[5] && (fault_flags & ~fault_interrupt_mask) == 8'h00
        && (input_flags & ~input_alarm_mask) == 8'h00 && (pll_flags & ~lock_holdover_mask) == 8'h00
        && (calib_flags & ~calib_busy_irq_mask) == 4'h0) |=> !irq)
        else $error("masked fault raised the interrupt");
    a_soft_all_pulse: assert property ((reg_req.wr && reg_req.addr == `ALMCR_ADDR_SOFT_RESET && reg_req.wdata[0])
        ##1 !(reg_req.wr && reg_req.addr == `ALMCR_ADDR_SOFT_RESET) |-> pulses.soft_all ##1 !pulses.soft_all)
        else $error("whole-device soft reset did not pulse once");
    a_pll_reset_map: assert property ((reg_req.wr && reg_req.addr == `ALMCR_ADDR_SOFT_RESET)
        |=> pulses.pll_soft == $past(reg_req.wdata[4:1]))
        else $error("per-PLL soft reset went to the wrong PLL");
    a_step_all_when_off: assert property ((reg_req.wr && reg_req.addr == `ALMCR_ADDR_FREQ_STEP && reg_req.wdata[0]
        && !step_target_select[0]) |=> pulses.step_up == 4'hf)
        else $error("step with single mode off did not reach all PLLs");
    a_step_pins: assert property ((reg_req.wr && reg_req.addr == `ALMCR_ADDR_FREQ_STEP && reg_req.wdata[1]
        && step_target_select[1:0] == 2'h1) |=> pulses.step_down == pll_onehot($past(pll_select_pins)))
        else $error("pin steering chose the wrong PLL");
    a_step_reserved: assert property ((reg_req.wr && reg_req.addr == `ALMCR_ADDR_FREQ_STEP
        && step_target_select == 4'h7) |=> pulses.step_up == 4'h0 && pulses.step_down == 4'h0)
        else $error("reserved select code stepped a PLL");
    a_sync_self_clear: assert property ((reg_req.wr && reg_req.addr == `ALMCR_ADDR_POWER_SYNC && reg_req.wdata[2])
        ##1 !reg_req.wr |-> pulses.div_sync ##1 !pulses.div_sync)
        else $error("divider sync did not clear itself");
    a_flag_set_wins: assert property ((alarm_in.fault[5] && reg_req.wr && reg_req.addr == `ALMCR_ADDR_FAULT_FLAGS
        && !reg_req.wdata[5]) |=> fault_flags[5])
        else $error("clear write lost a new fault event");
    a_loss_disabled: assert property (!signal_loss_enable[0] |=> !input_loss_alarm[0])
        else $error("disabled input raised a loss alarm");
    a_requal_wait: assert property ($fell(input_loss_alarm[0]) && signal_loss_enable[0] |-> $past(tick))
        else $error("loss alarm cleared off the requalification tick");

    c_step_register: cover property (pulses.step_up != 4'h0 && step_target_select[1:0] == 2'h3);
    c_irq_raised: cover property ($rose(irq));
    c_requal_done: cover property ($fell(input_loss_alarm[0]) && signal_loss_enable[0]);

endmodule : almcr_regs

`default_nettype wire

// *** testbench/almcr_host_model.sv ***
// Host controller model that issues register accesses to the bank.
`timescale 1ns/10ps
`default_nettype none
module almcr_host_model (
    input wire logic clock,
    output almcr_pkg::almcr_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
    // The port idles with no access at time zero.
    initial reg_req = '0;
    // One access is held through its taking edge, then released with inverted address and data.
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        #1;
        reg_req = '{wr: w, rd: !w, addr: a, wdata: (a == 8'h17) ? (d | 8'hc0) : d};
        @(posedge clock);
        #1;
        q = reg_rdata;
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : access
endmodule : almcr_host_model
`default_nettype wire

// *** testbench/test_alarm_mask_and_control_regs.sv ***
// Self-checking bench for the alarm mask and control bank.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_alarm_mask_and_control_regs;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    almcr_pkg::almcr_reg_req_t reg_req;
    almcr_pkg::almcr_alarm_in_t alarm_in = '0;
    almcr_pkg::almcr_pulse_t pulses;
    logic [7:0] reg_rdata, q;
    logic [1:0] pll_select_pins = 2'h0;
    logic output_enable_zero = 1'b0;
    logic all_outputs_gate = 1'b0;
    logic reg_rvalid, irq, low_power_request, hard_reset_request, three_wire_select, outputs_driven;
    logic crystal_loss_detect_disable;
    logic [3:0] input_loss_alarm, input_loss_detect_enable;
    logic [47:0] loss_trigger_threshold;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [7:0] cfg [6] = '{8'h00, 8'h0b, 8'h0f, 8'h03, 8'h01, 8'h07};
    logic [7:0] stb [6] = '{8'h01, 8'h02, 8'h01, 8'h02, 8'h01, 8'h01};
    logic [7:0] exp_step [6] = '{8'hf0, 8'h04, 8'h80, 8'h01, 8'h80, 8'h00};

    almcr_regs #(.TICK_CYCLES(4)) DUT (.clock(clock), .rst_b(rst_b), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .alarm_in(alarm_in),
        .pll_select_pins(pll_select_pins), .output_enable_zero(output_enable_zero),
        .all_outputs_gate(all_outputs_gate), .irq(irq), .pulses(pulses),
        .low_power_request(low_power_request), .hard_reset_request(hard_reset_request),
        .three_wire_select(three_wire_select), .outputs_driven(outputs_driven),
        .input_loss_alarm(input_loss_alarm), .input_loss_detect_enable(input_loss_detect_enable),
        .crystal_loss_detect_disable(crystal_loss_detect_disable),
        .loss_trigger_threshold(loss_trigger_threshold));
    almcr_host_model host (.clock(clock), .reg_req(reg_req), .reg_rdata(reg_rdata));

    // Clock of 8 ns period and a cycle ceiling that cuts a hang short.
    always #4 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            complete_run();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // Lets a number of edges pass, settling just after the last.
    task automatic edges(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : edges

    // Reset values, an unmapped read and a write-only read.
    task automatic t_reset();
        host.access(1'b0, 8'h17, 8'h00, q); `CHK(q, 8'h35)
        `CHK(reg_rvalid, 1'b1)
        edges(1); `CHK(reg_rvalid, 1'b0)
        host.access(1'b0, 8'h40, 8'h00, q); `CHK(q, 8'h00)
        host.access(1'b0, 8'h1c, 8'h00, q); `CHK(q, 8'h00)
    endtask : t_reset

    // Sticky fault raises the interrupt, the mask blocks it, a zero write clears it.
    task automatic t_irq();
        host.access(1'b1, 8'h17, 8'h00, q);
        alarm_in.fault[5] = 1'b1;
        edges(3); `CHK(irq, 1'b1)
        host.access(1'b1, 8'h17, 8'h20, q);
        edges(2); `CHK(irq, 1'b0)
        host.access(1'b1, 8'h11, 8'h00, q);
        host.access(1'b0, 8'h11, 8'h00, q); `CHK(q, 8'h20)
        alarm_in.fault[5] = 1'b0;
        host.access(1'b1, 8'h11, 8'h00, q);
        host.access(1'b1, 8'h17, 8'h00, q);
        edges(2); `CHK(irq, 1'b0)
        host.access(1'b0, 8'h11, 8'h00, q); `CHK(q, 8'h00)
    endtask : t_irq

    // Soft reset pulses last one cycle; a zero write does nothing.
    task automatic t_soft();
        host.access(1'b1, 8'h1c, 8'h1f, q); `CHK({pulses.soft_all, pulses.pll_soft}, 5'h1f)
        edges(1); `CHK({pulses.soft_all, pulses.pll_soft}, 5'h00)
        host.access(1'b1, 8'h1c, 8'h00, q); `CHK({pulses.soft_all, pulses.pll_soft}, 5'h00)
    endtask : t_soft

    // Step strobes steered by mode, source, field and pins, reserved code refused.
    task automatic t_step();
        pll_select_pins = 2'h3;
        for (int i = 0; i < 6; i++) begin
            host.access(1'b1, 8'h20, cfg[i], q);
            host.access(1'b1, 8'h1d, stb[i], q); `CHK({pulses.step_up, pulses.step_down}, exp_step[i])
            edges(1); `CHK({pulses.step_up, pulses.step_down}, 8'h00)
        end
    endtask : t_step

    // Power, sync, serial mode, thresholds and output gating.
    task automatic t_misc();
        host.access(1'b1, 8'h1e, 8'h07, q); `CHK(pulses.div_sync, 1'b1)
        edges(1); `CHK({hard_reset_request, low_power_request, pulses.div_sync}, 3'h6)
        host.access(1'b1, 8'h1e, 8'h00, q);
        edges(1); `CHK({hard_reset_request, low_power_request}, 2'h0)
        host.access(1'b1, 8'h2b, 8'h08, q);
        edges(1); `CHK(three_wire_select, 1'b1)
        host.access(1'b1, 8'h32, 8'h34, q);
        host.access(1'b1, 8'h33, 8'h12, q);
        edges(1); `CHK(loss_trigger_threshold[47:32], 16'h1234)
        output_enable_zero = 1'b1;
        all_outputs_gate = 1'b1;
        edges(2); `CHK(outputs_driven, 1'b1)
        all_outputs_gate = 1'b0;
        edges(2); `CHK(outputs_driven, 1'b0)
    endtask : t_misc

    // Input, lock and calibration masks hold back their own sticky flags.
    task automatic t_masks();
        host.access(1'b1, 8'h18, 8'h10, q);
        host.access(1'b1, 8'h19, 8'h01, q);
        host.access(1'b1, 8'h1a, 8'h10, q);
        alarm_in.offfreq = 4'h1;
        alarm_in.unlocked = 4'h1;
        alarm_in.calib = 4'h1;
        edges(3); `CHK(irq, 1'b0)
        alarm_in = '0;
        host.access(1'b0, 8'h12, 8'h00, q); `CHK(q, 8'h10)
        host.access(1'b0, 8'h14, 8'h00, q); `CHK(q, 8'h10)
        host.access(1'b1, 8'h19, 8'h00, q);
        edges(2); `CHK(irq, 1'b1)
        host.access(1'b1, 8'h13, 8'h00, q);
        edges(2); `CHK(irq, 1'b0)
    endtask : t_masks

    // Loss detection enables and the shortest requalification time.
    task automatic t_loss();
        host.access(1'b1, 8'h2c, 8'h11, q);
        host.access(1'b1, 8'h2d, 8'h00, q);
        edges(1); `CHK({crystal_loss_detect_disable, input_loss_detect_enable}, 5'h11)
        alarm_in.fault[1] = 1'b1;
        host.access(1'b0, 8'h11, 8'h00, q); `CHK(q, 8'h00)
        alarm_in.missing = 4'h3;
        edges(2); `CHK(input_loss_alarm, 4'h1)
        alarm_in.missing = 4'h0;
        edges(2); `CHK(input_loss_alarm, 4'h1)
        edges(14); `CHK(input_loss_alarm, 4'h0)
    endtask : t_loss

    // Reset for 20 cycles, then every scenario in turn.
    initial begin
        edges(20);
        rst_b = 1'b1;
        t_reset();
        t_irq();
        t_soft();
        t_step();
        t_misc();
        t_masks();
        t_loss();
        complete_run();
    end
endmodule : test_alarm_mask_and_control_regs
`default_nettype wire
